/* File: rtl/pcr_params.svh */
// Offsets, field positions, reset values and pin numbers of the pad block
`ifndef PCR_PARAMS_SVH
`define PCR_PARAMS_SVH

// Register byte addresses on the AXI4-Lite bus
`define PCR_ADDR_PULL_EN   8'h00
`define PCR_ADDR_POLARITY  8'h04
`define PCR_ADDR_OPEN_DR   8'h08
`define PCR_ADDR_ROUTING   8'h0c
`define PCR_ADDR_STATUS    8'h10

// Reset value of every configuration register
`define PCR_RST_CFG        8'h00

// Routing field positions
`define PCR_SCI_HI         7
`define PCR_SCI_LO         6
`define PCR_SPI_BIT        4

// Status field positions
`define PCR_ST_UP_LO       0
`define PCR_ST_DN_LO       8
`define PCR_ST_OE_LO       16
`define PCR_ST_SCI_LO      24

// Local pin numbers of the routed functions
`define PCR_CAN_RX_PIN     0
`define PCR_CAN_TX_PIN     1
`define PCR_SCI_RX_PIN     0
`define PCR_SCI_TX_PIN     1
`define PCR_SPI_MISO_PIN   2
`define PCR_SPI_MOSI_PIN   4
`define PCR_SPI_SCK_PIN    5
`define PCR_SPI_SS_PIN     3

// AXI response codes
`define PCR_RESP_OKAY      2'b00
`define PCR_RESP_SLVERR    2'b10

`endif

/* File: rtl/pcr_pkg.sv */
// Types shared by the pad configuration and routing block
package pcr_pkg;

  // Routing of the second asynchronous serial interface
  typedef enum logic [1:0] {
    PCR_SCI_PORT_S = 2'b00,
    PCR_SCI_PORT_P = 2'b01,
    PCR_SCI_LOCAL  = 2'b10,
    PCR_SCI_RSVD   = 2'b11
  } pcr_sci_route_t;

  // Register selected by a bus address
  typedef enum logic [2:0] {
    PCR_SEL_PULL_EN  = 3'b000,
    PCR_SEL_POLARITY = 3'b001,
    PCR_SEL_OPEN_DR  = 3'b010,
    PCR_SEL_ROUTING  = 3'b011,
    PCR_SEL_STATUS   = 3'b100,
    PCR_SEL_NONE     = 3'b111
  } pcr_reg_sel_t;

endpackage

/* File: rtl/pcr_pin_router.sv */
// Selects which function drives each local pin and its direction
`timescale 1ns/1ns
`include "pcr_params.svh"

module pcr_pin_router (
  // Configuration
  input  wire logic [7:0]             direction_bits_i,
  input  wire logic [7:0]             port_data_i,
  input  wire logic [7:0]             routing_control_i,
  // Peripheral requests
  input  wire logic                   can_active_i,
  input  wire logic                   can_tx_i,
  input  wire logic                   sci_enable_i,
  input  wire logic                   sci_txd_i,
  input  wire logic                   spi_enable_i,
  input  wire logic [3:0]             spi_out_i,
  input  wire logic [3:0]             spi_oe_i,
  // Per pin result and routing
  output logic      [7:0]             is_out_o,
  output logic      [7:0]             data_o,
  output logic      [7:0]             block_down_o,
  output pcr_pkg::pcr_sci_route_t     sci_route_o,
  output logic                        spi_local_o
);

  // Priority: CAN over SCI over SPI-free GPIO; SPI owns pins 2-5
  always_comb begin
    sci_route_o  = pcr_pkg::pcr_sci_route_t'(
                     routing_control_i[`PCR_SCI_HI:`PCR_SCI_LO]);
    if (sci_route_o == pcr_pkg::PCR_SCI_RSVD) begin
      sci_route_o = pcr_pkg::PCR_SCI_PORT_S;
    end
    spi_local_o  = routing_control_i[`PCR_SPI_BIT];
    is_out_o     = direction_bits_i;
    data_o       = port_data_i;
    block_down_o = 8'h00;
    if (sci_enable_i && sci_route_o == pcr_pkg::PCR_SCI_LOCAL) begin
      is_out_o[`PCR_SCI_RX_PIN] = 1'b0;
      is_out_o[`PCR_SCI_TX_PIN] = 1'b1;
      data_o[`PCR_SCI_TX_PIN]   = sci_txd_i;
    end
    if (can_active_i) begin
      is_out_o[`PCR_CAN_RX_PIN]     = 1'b0;
      is_out_o[`PCR_CAN_TX_PIN]     = 1'b1;
      data_o[`PCR_CAN_TX_PIN]       = can_tx_i;
      block_down_o[`PCR_CAN_RX_PIN] = 1'b1;
    end
    if (spi_enable_i && spi_local_o) begin
      is_out_o[`PCR_SPI_MISO_PIN] = spi_oe_i[0];
      data_o[`PCR_SPI_MISO_PIN]   = spi_out_i[0];
      is_out_o[`PCR_SPI_MOSI_PIN] = spi_oe_i[1];
      data_o[`PCR_SPI_MOSI_PIN]   = spi_out_i[1];
      is_out_o[`PCR_SPI_SCK_PIN]  = spi_oe_i[2];
      data_o[`PCR_SPI_SCK_PIN]    = spi_out_i[2];
      is_out_o[`PCR_SPI_SS_PIN]   = spi_oe_i[3];
      data_o[`PCR_SPI_SS_PIN]     = spi_out_i[3];
    end
  end

endmodule // pcr_pin_router

/* File: rtl/pcr_pad_cell.sv */
// Registered pad control of one pin: drive, enable and pull devices
`timescale 1ns/1ns

module pcr_pad_cell (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  // Function and configuration
  input  wire logic is_out_i,
  input  wire logic data_i,
  input  wire logic pull_en_i,
  input  wire logic pull_dn_sel_i,
  input  wire logic open_drain_i,
  input  wire logic block_down_i,
  // Pad controls
  output logic      pad_o,
  output logic      pad_oe_o,
  output logic      pull_up_o,
  output logic      pull_down_o
);

  logic pad_nxt;
  logic oe_nxt;
  logic up_nxt;
  logic dn_nxt;
  logic pull_on;

  // Output buffer and pull device selection
  always_comb begin
    pull_on = 1'b0;
    pad_nxt = 1'b0;
    oe_nxt  = 1'b0;
    if (is_out_i) begin
      if (open_drain_i) begin
        pad_nxt = 1'b0;
        oe_nxt  = ~data_i;
        pull_on = pull_en_i;
      end else begin
        pad_nxt = data_i;
        oe_nxt  = 1'b1;
      end
    end else begin
      pull_on = pull_en_i;
    end
    up_nxt = pull_on & ~pull_dn_sel_i;
    dn_nxt = pull_on & pull_dn_sel_i & ~block_down_i;
  end

  // Pad control flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pad_o       <= 1'b0;
      pad_oe_o    <= 1'b0;
      pull_up_o   <= 1'b0;
      pull_down_o <= 1'b0;
    end else if (ce_i) begin
      pad_o       <= pad_nxt;
      pad_oe_o    <= oe_nxt;
      pull_up_o   <= up_nxt;
      pull_down_o <= dn_nxt;
    end
  end

  // Checks of pad behaviour
  property p_in_pull;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && !is_out_i |=>
        (pull_up_o | pull_down_o) ==
        ($past(pull_en_i) && !($past(pull_dn_sel_i) && $past(block_down_i)));
  endproperty
  a_in_pull: assert property (p_in_pull)
    else $error("pull device does not follow enable on input pin");

  property p_out_pp_no_pull;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && is_out_i && !open_drain_i |=> !pull_up_o && !pull_down_o;
  endproperty
  a_out_pp_no_pull: assert property (p_out_pp_no_pull)
    else $error("pull device active on push-pull output");

  property p_polarity;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && pull_en_i && !is_out_i && !block_down_i |=>
        pull_down_o == $past(pull_dn_sel_i) &&
        pull_up_o == !$past(pull_dn_sel_i);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pull polarity wrong");

  property p_push_pull;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && is_out_i && !open_drain_i |=>
        pad_oe_o && pad_o == $past(data_i);
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull output not driven");

  property p_open_drain;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && is_out_i && open_drain_i |=>
        !pad_o && (pad_oe_o != $past(data_i));
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain drive wrong");

  property p_input_undriven;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && !is_out_i |=> !pad_oe_o;
  endproperty
  a_input_undriven: assert property (p_input_undriven)
    else $error("input pin driven");

endmodule // pcr_pad_cell

/* File: rtl/pcr_port_pad_cfg.sv */
// Pad configuration and peripheral routing for one 8-bit port
// What this block does
// - Pull-enable bit one turns the pull device on for an input pin.
// - On an output pin the pull enable acts only in open-drain mode.
// - Polarity bit one picks pull-down, zero picks pull-up.
// - With CAN active a pull-down on its receive pin does nothing.
// - Open-drain bit set gives open-drain, clear gives push-pull, any function.
// - Open-drain drives low for zero and leaves the pin free for one.
// - Open-drain bit never affects a pin used as input.
// - Serial routing bits 7:6 pick port S, port P or local pins.
// - Reserved serial routing code 11 acts like the reset routing.
// - Routing bit 4 moves the synchronous serial pins to local 2,4,5,3.
// - Direction one makes the pin an output, zero an input.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "pcr_params.svh"

module pcr_port_pad_cfg (
  // Clock, reset and enable
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Port logic outside this block
  input  wire logic [7:0]  direction_bits_i,
  input  wire logic [7:0]  port_data_i,
  // Peripherals
  input  wire logic        can_active_i,
  input  wire logic        can_tx_i,
  input  wire logic        sci_enable_i,
  input  wire logic        sci_txd_i,
  input  wire logic        spi_enable_i,
  input  wire logic [3:0]  spi_out_i,
  input  wire logic [3:0]  spi_oe_i,
  output logic             can_rx_o,
  output logic             sci_rxd_o,
  output logic [3:0]       spi_in_o,
  // Routing seen by the other ports
  output logic [1:0]       sci_route_o,
  output logic             spi_local_o,
  // Pads
  input  wire logic [7:0]  pin_i,
  output logic [7:0]       pin_o,
  output logic [7:0]       pin_oe_o,
  output logic [7:0]       pull_up_o,
  output logic [7:0]       pull_down_o
);

  // Configuration registers
  logic [7:0]  pull_enable_bits_r, pull_enable_bits_nxt;
  logic [7:0]  pull_polarity_bits_r, pull_polarity_bits_nxt;
  logic [7:0]  open_drain_bits_r, open_drain_bits_nxt;
  logic [7:0]  routing_control_r, routing_control_nxt;
  // Bus state
  logic        aw_held_r, aw_held_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic        w_held_r, w_held_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        wlane_r, wlane_nxt;
  logic        awready_nxt, wready_nxt, arready_nxt;
  logic        bvalid_nxt, rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt;
  // Routed peripheral inputs and routing outputs
  logic        can_rx_nxt, sci_rxd_nxt, spi_local_nxt;
  logic [3:0]  spi_in_nxt;
  logic [1:0]  sci_route_nxt;
  // Router results
  logic [7:0]  is_out, pin_data, block_down;
  logic        spi_local;
  pcr_pkg::pcr_sci_route_t sci_route;
  pcr_pkg::pcr_reg_sel_t   wsel, rsel;

  // Address decode
  function automatic pcr_pkg::pcr_reg_sel_t decode(input logic [7:0] a);
    if (a == `PCR_ADDR_PULL_EN) begin
      decode = pcr_pkg::PCR_SEL_PULL_EN;
    end else if (a == `PCR_ADDR_POLARITY) begin
      decode = pcr_pkg::PCR_SEL_POLARITY;
    end else if (a == `PCR_ADDR_OPEN_DR) begin
      decode = pcr_pkg::PCR_SEL_OPEN_DR;
    end else if (a == `PCR_ADDR_ROUTING) begin
      decode = pcr_pkg::PCR_SEL_ROUTING;
    end else if (a == `PCR_ADDR_STATUS) begin
      decode = pcr_pkg::PCR_SEL_STATUS;
    end else begin
      decode = pcr_pkg::PCR_SEL_NONE;
    end
  endfunction

  // Function selection per pin
  pcr_pin_router u_router (
    .direction_bits_i  (direction_bits_i),
    .port_data_i       (port_data_i),
    .routing_control_i (routing_control_r),
    .can_active_i      (can_active_i),
    .can_tx_i          (can_tx_i),
    .sci_enable_i      (sci_enable_i),
    .sci_txd_i         (sci_txd_i),
    .spi_enable_i      (spi_enable_i),
    .spi_out_i         (spi_out_i),
    .spi_oe_i          (spi_oe_i),
    .is_out_o          (is_out),
    .data_o            (pin_data),
    .block_down_o      (block_down),
    .sci_route_o       (sci_route),
    .spi_local_o       (spi_local)
  );

  // One pad cell per pin
  for (genvar g = 0; g < 8; g++) begin : g_pad
    pcr_pad_cell u_pad (
      .clk_i         (clk_i),
      .resetn_i      (resetn_i),
      .ce_i          (ce_i),
      .is_out_i      (is_out[g]),
      .data_i        (pin_data[g]),
      .pull_en_i     (pull_enable_bits_r[g]),
      .pull_dn_sel_i (pull_polarity_bits_r[g]),
      .open_drain_i  (open_drain_bits_r[g]),
      .block_down_i  (block_down[g]),
      .pad_o         (pin_o[g]),
      .pad_oe_o      (pin_oe_o[g]),
      .pull_up_o     (pull_up_o[g]),
      .pull_down_o   (pull_down_o[g])
    );
  end

  // Bus slave and register file next values
  always_comb begin
    pull_enable_bits_nxt   = pull_enable_bits_r;
    pull_polarity_bits_nxt = pull_polarity_bits_r;
    open_drain_bits_nxt    = open_drain_bits_r;
    routing_control_nxt    = routing_control_r;
    aw_held_nxt = aw_held_r;
    awaddr_nxt  = awaddr_r;
    w_held_nxt  = w_held_r;
    wdata_nxt   = wdata_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = s_axi_bvalid_o;
    bresp_nxt   = s_axi_bresp_o;
    rvalid_nxt  = s_axi_rvalid_o;
    rdata_nxt   = s_axi_rdata_o;
    rresp_nxt   = s_axi_rresp_o;
    wsel        = decode(awaddr_r);
    rsel        = decode(s_axi_araddr_i);
    // Capture address and data in either order
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata_i[7:0];
      wlane_nxt  = s_axi_wstrb_i[0];
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      bvalid_nxt = 1'b0;
    end
    // Perform the write once both halves are held
    if (aw_held_r && w_held_r && !s_axi_bvalid_o) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `PCR_RESP_OKAY;
      if (wsel == pcr_pkg::PCR_SEL_PULL_EN) begin
        if (wlane_r) pull_enable_bits_nxt = wdata_r;
      end else if (wsel == pcr_pkg::PCR_SEL_POLARITY) begin
        if (wlane_r) pull_polarity_bits_nxt = wdata_r;
      end else if (wsel == pcr_pkg::PCR_SEL_OPEN_DR) begin
        if (wlane_r) open_drain_bits_nxt = wdata_r;
      end else if (wsel == pcr_pkg::PCR_SEL_ROUTING) begin
        if (wlane_r) routing_control_nxt = wdata_r;
      end else begin
        bresp_nxt = `PCR_RESP_SLVERR;
      end
    end
    // Read answered at the same edge that takes the address
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `PCR_RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (rsel == pcr_pkg::PCR_SEL_PULL_EN) begin
        rdata_nxt[7:0] = pull_enable_bits_r;
      end else if (rsel == pcr_pkg::PCR_SEL_POLARITY) begin
        rdata_nxt[7:0] = pull_polarity_bits_r;
      end else if (rsel == pcr_pkg::PCR_SEL_OPEN_DR) begin
        rdata_nxt[7:0] = open_drain_bits_r;
      end else if (rsel == pcr_pkg::PCR_SEL_ROUTING) begin
        rdata_nxt[7:0] = routing_control_r;
      end else if (rsel == pcr_pkg::PCR_SEL_STATUS) begin
        rdata_nxt[`PCR_ST_UP_LO +: 8]  = pull_up_o;
        rdata_nxt[`PCR_ST_DN_LO +: 8]  = pull_down_o;
        rdata_nxt[`PCR_ST_OE_LO +: 8]  = pin_oe_o;
        rdata_nxt[`PCR_ST_SCI_LO +: 2] = sci_route_o;
      end else begin
        rresp_nxt = `PCR_RESP_SLVERR;
      end
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
    // Local pins feed routed peripheral inputs
    can_rx_nxt    = pin_i[`PCR_CAN_RX_PIN];
    sci_rxd_nxt   = pin_i[`PCR_SCI_RX_PIN];
    spi_in_nxt    = {pin_i[`PCR_SPI_SS_PIN], pin_i[`PCR_SPI_SCK_PIN],
                     pin_i[`PCR_SPI_MOSI_PIN], pin_i[`PCR_SPI_MISO_PIN]};
    sci_route_nxt = sci_route;
    spi_local_nxt = spi_local;
  end

  // State registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pull_enable_bits_r   <= `PCR_RST_CFG;
      pull_polarity_bits_r <= `PCR_RST_CFG;
      open_drain_bits_r    <= `PCR_RST_CFG;
      routing_control_r    <= `PCR_RST_CFG;
      aw_held_r            <= 1'b0;
      awaddr_r             <= 8'h00;
      w_held_r             <= 1'b0;
      wdata_r              <= 8'h00;
      wlane_r              <= 1'b0;
      s_axi_awready_o      <= 1'b0;
      s_axi_wready_o       <= 1'b0;
      s_axi_bvalid_o       <= 1'b0;
      s_axi_bresp_o        <= `PCR_RESP_OKAY;
      s_axi_arready_o      <= 1'b0;
      s_axi_rvalid_o       <= 1'b0;
      s_axi_rdata_o        <= 32'h0000_0000;
      s_axi_rresp_o        <= `PCR_RESP_OKAY;
      can_rx_o             <= 1'b0;
      sci_rxd_o            <= 1'b0;
      spi_in_o             <= 4'h0;
      sci_route_o          <= 2'h0;
      spi_local_o          <= 1'b0;
    end else if (ce_i) begin
      pull_enable_bits_r   <= pull_enable_bits_nxt;
      pull_polarity_bits_r <= pull_polarity_bits_nxt;
      open_drain_bits_r    <= open_drain_bits_nxt;
      routing_control_r    <= routing_control_nxt;
      aw_held_r            <= aw_held_nxt;
      awaddr_r             <= awaddr_nxt;
      w_held_r             <= w_held_nxt;
      wdata_r              <= wdata_nxt;
      wlane_r              <= wlane_nxt;
      s_axi_awready_o      <= awready_nxt;
      s_axi_wready_o       <= wready_nxt;
      s_axi_bvalid_o       <= bvalid_nxt;
      s_axi_bresp_o        <= bresp_nxt;
      s_axi_arready_o      <= arready_nxt;
      s_axi_rvalid_o       <= rvalid_nxt;
      s_axi_rdata_o        <= rdata_nxt;
      s_axi_rresp_o        <= rresp_nxt;
      can_rx_o             <= can_rx_nxt;
      sci_rxd_o            <= sci_rxd_nxt;
      spi_in_o             <= spi_in_nxt;
      sci_route_o          <= sci_route_nxt;
      spi_local_o          <= spi_local_nxt;
    end
  end

  // Checks of routing, direction and register behaviour
  property p_can_no_pulldown;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && can_active_i |=> !pull_down_o[`PCR_CAN_RX_PIN];
  endproperty
  a_can_no_pulldown: assert property (p_can_no_pulldown)
    else $error("pull-down active on CAN receive pin");
  property p_sci_route;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && routing_control_r[7:6] != 2'b11 |=>
        sci_route_o == $past(routing_control_r[7:6]);
  endproperty
  a_sci_route: assert property (p_sci_route)
    else $error("serial routing output wrong");
  property p_sci_rsvd;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && routing_control_r[7:6] == 2'b11 |=> sci_route_o == 2'b00;
  endproperty
  a_sci_rsvd: assert property (p_sci_rsvd)
    else $error("reserved serial routing not treated as reset value");
  property p_spi_local;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && spi_enable_i && routing_control_r[4] && spi_oe_i[1] &&
      !open_drain_bits_r[4] |=>
        spi_local_o && pin_oe_o[4] && pin_o[4] == $past(spi_out_i[1]);
  endproperty
  a_spi_local: assert property (p_spi_local)
    else $error("synchronous serial output not on local pin");
  property p_direction;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && !can_active_i && !sci_enable_i && !spi_enable_i &&
      !open_drain_bits_r[7] |=> pin_oe_o[7] == $past(direction_bits_i[7]);
  endproperty
  a_direction: assert property (p_direction)
    else $error("direction bit not applied");
  property p_readback;
    @(posedge clk_i) disable iff (!resetn_i)
      ce_i && aw_held_r && w_held_r && !s_axi_bvalid_o && wlane_r &&
      awaddr_r == `PCR_ADDR_OPEN_DR ##1 ce_i[*2] |->
        open_drain_bits_r == $past(wdata_r, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("written value not stored");

  c_open_drain: cover property (@(posedge clk_i) disable iff (!resetn_i)
    pin_oe_o[2] ##1 !pin_oe_o[2] && open_drain_bits_r[2]);
  c_sci_local: cover property (@(posedge clk_i) disable iff (!resetn_i)
    sci_route_o == 2'b10 && sci_enable_i);
  c_rd_status: cover property (@(posedge clk_i) disable iff (!resetn_i)
    s_axi_rvalid_o && s_axi_rready_i && s_axi_rdata_o[23:16] != 8'h00);

endmodule // pcr_port_pad_cfg

/* File: testbench/pcr_line_model.sv */
// Shared external lines: driven, pulled or left floating
`timescale 1ns/1ns

module pcr_line_model (
  // Clock
  input  wire logic       clk_i,
  // Pad controls from the block
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pull_up_i,
  input  wire logic [7:0] pull_down_i,
  // Line levels seen by the block
  output logic      [7:0] pin_i_o
);
  logic [7:0] last_r = 8'h00;

  // Floating line flips so a stale value never looks valid
  always_ff @(posedge clk_i) last_r <= pin_i_o;

  // Resolve each line from driver and pull devices
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_i[i]) pin_i_o[i] = pin_o_i[i];
      else if (pull_up_i[i]) pin_i_o[i] = 1'b1;
      else if (pull_down_i[i]) pin_i_o[i] = 1'b0;
      else pin_i_o[i] = ~last_r[i];
    end
  end
endmodule // pcr_line_model

/* File: testbench/tb.sv */
// Register and pad tests of the port pad configuration block
`timescale 1ns/1ns

module tb;
  logic clk_i = 0, resetn_i = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic ce = 1, can_rx;
  logic [7:0] aw = 0, ar = 0, dir = 0, dat = 0, po, poe, pu, pd, pin;
  logic [31:0] wd = 0, rdat, rd_d;
  logic [1:0] rsp, rresp, sroute, brs, bsp;
  logic can_a = 0, can_t = 0, sci_e = 0, sci_t = 0, spi_e = 0;
  logic [3:0] spi_o = 0, spi_oe = 0, spi_in;
  logic awr, wrd, bv, arr, rv, sci_rx, sloc;
  logic [7:0] codes [4] = '{8'h10, 8'h40, 8'h80, 8'hc0};
  logic [2:0] exps [4] = '{3'b001, 3'b010, 3'b100, 3'b000};
  int failures = 0, total_checks = 0;

  always #10 clk_i = ~clk_i;

  pcr_port_pad_cfg u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wrd), .s_axi_bresp_o(brs), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .direction_bits_i(dir),
    .port_data_i(dat), .can_active_i(can_a), .can_tx_i(can_t),
    .sci_enable_i(sci_e), .sci_txd_i(sci_t), .spi_enable_i(spi_e),
    .spi_out_i(spi_o), .spi_oe_i(spi_oe), .can_rx_o(can_rx),
    .sci_rxd_o(sci_rx),
    .spi_in_o(spi_in), .sci_route_o(sroute), .spi_local_o(sloc),
    .pin_i(pin), .pin_o(po), .pin_oe_o(poe), .pull_up_o(pu),
    .pull_down_o(pd));

  pcr_line_model u_line (.clk_i(clk_i), .pin_o_i(po), .pin_oe_i(poe),
    .pull_up_i(pu), .pull_down_i(pd), .pin_i_o(pin));

  // Compare one result
  task chk(input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task results;
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Bus write, channels released as each is taken
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    aw  <= a;
    wd  <= {24'h0, d};
    awv <= 1;
    wv  <= 1;
    bre <= 1;
    do begin
      @(posedge clk_i);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (bv !== 1'b1);
    bsp = brs;
    bre <= 0;
  endtask

  // Bus read, data taken one edge after the answering edge
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    ar  <= a;
    arv <= 1;
    rre <= 1;
    do begin
      @(posedge clk_i);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    rdat = rd_d;
    rsp  = rresp;
    rre <= 0;
  endtask

  task w3;
    repeat (3) @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    results;
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1;
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4));
      chk({rsp, rdat}, 0);
    end
    rd(8'h20);
    chk({rsp, rdat}, {2'b10, 32'h0});
    wr(8'h10, 8'h55);
    chk(bsp, 2'b10);
    wr(8'h04, 8'h0f);
    chk(bsp, 2'b00);
    rd(8'h04);
    chk({rsp, rdat}, 34'h0f);
    wr(8'h00, 8'hff);
    w3;
    chk({pu, pd}, 16'hf00f);
    dir <= 8'hff;
    dat <= 8'h0f;
    w3;
    chk({poe, pu, pd, po}, 32'hff00000f);
    wr(8'h08, 8'hff);
    w3;
    chk({po, poe, pu, pd}, 32'h00f0f00f);
    rd(8'h10);
    chk({rsp, rdat}, 34'h00f00ff0);
    dir <= 8'h00;
    w3;
    chk(poe, 0);
    ce  <= 0;
    dir <= 8'hff;
    w3;
    chk(poe, 0);
    ce  <= 1;
    dir <= 8'h00;
    can_a <= 1;
    w3;
    chk({pd, poe}, 16'h0e02);
    can_a <= 0;
    sci_e <= 1;
    sci_t <= 0;
    wr(8'h0c, 8'h80);
    wr(8'h04, 8'h00);
    w3;
    chk({sroute, po[1], poe[1], sci_rx, can_rx}, 6'b100111);
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, codes[i]);
      w3;
      chk({sroute, sloc}, exps[i]);
    end
    wr(8'h0c, 8'h10);
    wr(8'h08, 8'h00);
    spi_e  <= 1;
    spi_oe <= 4'b0010;
    spi_o  <= 4'b0010;
    w3;
    chk({po[4], poe[4], spi_in}, 6'h3f);
    results;
  end
endmodule // tb
